//--- core/afe_event_regs.svh
// Register offsets, field positions, reset values and timing counts of the front end event block
`ifndef AFE_EVENT_REGS_SVH
`define AFE_EVENT_REGS_SVH

`define CTRL_OFS          8'h00
`define CMP_CFG_OFS       8'h04
`define EDGE_MASK_OFS     8'h08
`define PROT_MASK_OFS     8'h0c
`define THRESH_OFS        8'h10
`define IO_CFG_OFS        8'h14
`define IO_DATA_OFS       8'h18
`define STATUS_OFS        8'h1c
`define EDGE_FLAG_OFS     8'h20
`define AMP_CFG_OFS       8'h24
`define SCAN_MASK_OFS     8'h28
`define CMP_ROUTE_OFS     8'h2c
`define IO_ROUTE_OFS      8'h30

`define CTRL_PB_EN_BIT    0
`define CTRL_HIB_BIT      1
`define CTRL_AUTO_BIT     2
`define CTRL_SEL_LSB      4
`define STAT_PB_LEVEL_BIT 16
`define STAT_PB_EVENT_BIT 17
`define STAT_HIB_BIT      18

`define REG_RESET         32'h0000_0000

`define CLK_FREQ_HZ       40000000
`define LONG_PRESS_S      8
`define LONG_PRESS_CYC    (`LONG_PRESS_S * `CLK_FREQ_HZ)

`endif

//--- core/afe_event_pkg.sv
// Types shared by the front end event block and its users
package afe_event_pkg;

    typedef enum logic [2:0] {
        GAIN_1X    = 3'h0,
        GAIN_2X    = 3'h1,
        GAIN_4X    = 3'h2,
        GAIN_8X    = 3'h3,
        GAIN_16X   = 3'h4,
        GAIN_32X   = 3'h5,
        GAIN_48X   = 3'h6,
        GAIN_THRU  = 3'h7
    } gain_type;

    typedef enum logic [1:0] {
        REF_THRESHOLD = 2'h0,
        REF_MATRIX    = 2'h1,
        REF_PHASE_AVG = 2'h3
    } phase_ref_type;

    typedef struct packed {
        gain_type [2:0]      diff_gain;
        logic     [2:0]      sample_hold;
        gain_type [3:0]      single_gain;
        logic     [3:0]      gp_ref_matrix;
        phase_ref_type [2:0] phase_ref;
        logic     [7:0]      high_speed_threshold_code;
        logic     [9:0]      limit_threshold_code;
    } analog_cfg_type;

endpackage : afe_event_pkg

//--- core/afe_event_router.sv
// Front end event routing, pin control and push button logic with an AHB-Lite register slave
`timescale 1ns/1ps
`include "afe_event_regs.svh"

// Notes on behaviour
// - Each general comparator has rise and fall masks gating edges onto second interrupt.
// - General comparator output gets polarity, then goes to a data bit or matrix line.
// - General comparator reference is threshold level or an analog matrix signal.
// - Phase comparator output goes to a data bit and sequencer-timed position mux.
// - Phase comparator reference may also be the averaged phase voltage.
// - Two protection comparators per differential amplifier, readable and usable as events.
// - Each protection comparator has a mask enabling the main interrupt.
// - Each protection comparator has separate masks for protection events one and two.
// - Protection events go straight to the power driver protection logic.
// - High speed threshold code is 8 bits, limit threshold code is 10 bits.
// - Front end pins act as input or open drain output, via register or matrix.
// - Each front end pin has selectable active level, active high after reset.
// - Four interrupt-capable pins have rise and fall masks onto second interrupt.
// - Enabled push button is active low; press is reported, and wakes from hibernate.
// - Push button held low over eight seconds resets the controller in normal operation.
// - ADC selector picks one of sixteen sources, directly or by automatic scanning.
// - Each differential amplifier output goes direct or via sample and hold.
// - Gains are 1x to 48x in seven steps; single-ended adds feed-through.
// - Digital matrix has seven bidirectional lines for pins, comparators and drivers.
module afe_event_router #(
    parameter int LONG_PRESS_CYCLES = `LONG_PRESS_CYC
) (
    input  wire logic                        MCLK_IN,
    input  wire logic                        RST_N_IN,
    input  wire logic                        HSEL_IN,
    input  wire logic [31:0]                 HADDR_IN,
    input  wire logic [1:0]                  HTRANS_IN,
    input  wire logic                        HWRITE_IN,
    input  wire logic [2:0]                  HSIZE_IN,
    input  wire logic [31:0]                 HWDATA_IN,
    input  wire logic                        HREADY_IN,
    output logic      [31:0]                 HRDATA_OUT,
    output logic                             HREADYOUT_OUT,
    output logic                             HRESP_OUT,
    input  wire logic [3:0]                  GENERAL_COMPARATOR_IN,
    input  wire logic [2:0]                  PHASE_COMPARATOR_IN,
    input  wire logic [5:0]                  PROTECTION_COMPARATOR_IN,
    input  wire logic                        PUSH_BUTTON_INPUT_N_IN,
    input  wire logic [9:0]                  FRONT_END_IO_PIN_IN,
    output logic      [9:0]                  FRONT_END_IO_PIN_OUT,
    output logic      [9:0]                  FRONT_END_IO_PIN_OE_OUT,
    input  wire logic [6:0]                  DIGITAL_SIGNAL_MATRIX_IN,
    output logic      [6:0]                  DIGITAL_SIGNAL_MATRIX_OUT,
    output logic      [6:0]                  DIGITAL_SIGNAL_MATRIX_OE_OUT,
    input  wire logic                        ADC_SCAN_STEP_IN,
    output logic      [3:0]                  ADC_INPUT_SELECT_OUT,
    output logic      [2:0]                  PHASE_POSITION_OUT,
    output afe_event_pkg::analog_cfg_type    ANALOG_CFG_OUT,
    output logic                             MAIN_INTERRUPT_LINE_OUT,
    output logic                             SECOND_INTERRUPT_LINE_OUT,
    output logic                             PROTECTION_EVENT_ONE_OUT,
    output logic                             PROTECTION_EVENT_TWO_OUT,
    output logic                             HIBERNATE_OUT,
    output logic                             WAKE_OUT,
    output logic                             CONTROLLER_RESET_OUT
);
    import afe_event_pkg::*;

    localparam int SYNC_W = 31;

    logic [31:0]       ctrl_q;
    logic [31:0]       cmp_cfg_q;
    logic [31:0]       edge_mask_q;
    logic [31:0]       prot_mask_q;
    logic [31:0]       thresh_q;
    logic [31:0]       io_cfg_q;
    logic [31:0]       io_data_q;
    logic [31:0]       amp_cfg_q;
    logic [31:0]       scan_mask_q;
    logic [31:0]       cmp_route_q;
    logic [31:0]       io_route_q;
    logic [15:0]       edge_flag_q;
    logic              pb_event_q;
    logic              hib_q;
    logic              wake_q;
    logic              rst_out_q;
    logic [31:0]       press_cnt_q;
    logic [3:0]        scan_sel_q;
    logic [2:0]        position_q;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] prev_q;
    logic              wr_pend_q;
    logic              rd_pend_q;
    logic [7:0]        addr_q;
    logic [31:0]       rdata_q;

    logic [SYNC_W-1:0] raw;
    logic [3:0]        gp_val;
    logic [3:0]        gp_prev;
    logic [2:0]        ph_val;
    logic [5:0]        prot_val;
    logic              pb_low;
    logic              pb_low_prev;
    logic [9:0]        io_in_val;
    logic [9:0]        io_prev_val;
    logic [6:0]        matrix_val;
    logic [15:0]       edge_set;
    logic [9:0]        io_out_val;
    logic              addr_ok;
    logic              wr_en;
    logic [31:0]       rd_mux;

    // Input synchronisers
    assign raw = {DIGITAL_SIGNAL_MATRIX_IN, FRONT_END_IO_PIN_IN, PUSH_BUTTON_INPUT_N_IN,
                  PROTECTION_COMPARATOR_IN, PHASE_COMPARATOR_IN, GENERAL_COMPARATOR_IN};

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign gp_val      = sync2_q[3:0] ^ cmp_cfg_q[3:0];
    assign gp_prev     = prev_q[3:0] ^ cmp_cfg_q[3:0];
    assign ph_val      = sync2_q[6:4] ^ cmp_cfg_q[14:12];
    assign prot_val    = sync2_q[12:7];
    assign pb_low      = ctrl_q[`CTRL_PB_EN_BIT] & ~sync2_q[13];
    assign pb_low_prev = ctrl_q[`CTRL_PB_EN_BIT] & ~prev_q[13];
    assign io_in_val   = sync2_q[23:14] ^ io_cfg_q[25:16];
    assign io_prev_val = prev_q[23:14] ^ io_cfg_q[25:16];
    assign matrix_val  = sync2_q[30:24];

    // Edge requests: general comparators then interrupt-capable pins 6..9
    always_comb begin
        edge_set = '0;
        for (int i = 0; i < 4; i++) begin
            edge_set[i]      = edge_mask_q[i] & gp_val[i] & ~gp_prev[i];
            edge_set[4 + i]  = edge_mask_q[4 + i] & ~gp_val[i] & gp_prev[i];
            edge_set[8 + i]  = edge_mask_q[8 + i] & ~io_cfg_q[6 + i]
                               & io_in_val[6 + i] & ~io_prev_val[6 + i];
            edge_set[12 + i] = edge_mask_q[12 + i] & ~io_cfg_q[6 + i]
                               & ~io_in_val[6 + i] & io_prev_val[6 + i];
        end
    end

    // Interrupts and protection events
    assign SECOND_INTERRUPT_LINE_OUT = |edge_flag_q;
    assign MAIN_INTERRUPT_LINE_OUT   = |(prot_val & prot_mask_q[5:0]);
    assign PROTECTION_EVENT_ONE_OUT  = |(prot_val & prot_mask_q[13:8]);
    assign PROTECTION_EVENT_TWO_OUT  = |(prot_val & prot_mask_q[21:16]);

    // Front end pins: open drain pulls low when the pin level is low
    genvar p;
    generate
        for (p = 0; p < 10; p++) begin : g_io
            logic [2:0] line;
            assign line = io_route_q[3*p +: 3];
            assign io_out_val[p] = (line != 3'h0) ? matrix_val[line - 3'h1] : io_data_q[p];
            assign FRONT_END_IO_PIN_OUT[p]    = 1'b0;
            assign FRONT_END_IO_PIN_OE_OUT[p] = io_cfg_q[p] & ~(io_out_val[p] ^ io_cfg_q[16 + p]);
        end
    endgenerate

    // Digital matrix lines: driven by routed comparators and input pins
    genvar k;
    generate
        for (k = 0; k < 7; k++) begin : g_line
            logic [3:0] gp_hit;
            logic [9:0] io_hit;
            for (genvar c = 0; c < 4; c++) begin : g_gp
                assign gp_hit[c] = cmp_cfg_q[4 + c] && (cmp_route_q[3*c +: 3] == 3'(k + 1));
            end
            for (genvar j = 0; j < 10; j++) begin : g_pin
                assign io_hit[j] = ~io_cfg_q[j] && (io_route_q[3*j +: 3] == 3'(k + 1));
            end
            assign DIGITAL_SIGNAL_MATRIX_OE_OUT[k] = |gp_hit | |io_hit;
            assign DIGITAL_SIGNAL_MATRIX_OUT[k]    = |(gp_hit & gp_val) | |(io_hit & io_in_val);
        end
    endgenerate

    // Analog configuration
    genvar a;
    generate
        for (a = 0; a < 4; a++) begin : g_gain
            assign ANALOG_CFG_OUT.single_gain[a] = gain_type'(amp_cfg_q[12 + 3*a +: 3]);

            if (a < 3) begin : g_three
                assign ANALOG_CFG_OUT.diff_gain[a] = gain_type'(amp_cfg_q[3*a +: 3]);
                assign ANALOG_CFG_OUT.phase_ref[a] = phase_ref_type'(cmp_cfg_q[16 + 2*a +: 2]);
            end
        end
    endgenerate

    assign ANALOG_CFG_OUT.sample_hold               = amp_cfg_q[11:9];
    assign ANALOG_CFG_OUT.gp_ref_matrix             = cmp_cfg_q[11:8];
    assign ANALOG_CFG_OUT.high_speed_threshold_code = thresh_q[7:0];
    assign ANALOG_CFG_OUT.limit_threshold_code      = thresh_q[25:16];

    // ADC selector: direct or scanned, masked sources skipped
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            scan_sel_q <= 4'h0;
        end else if (!ctrl_q[`CTRL_AUTO_BIT]) begin
            scan_sel_q <= ctrl_q[`CTRL_SEL_LSB +: 4];
        end else if (ADC_SCAN_STEP_IN || scan_mask_q[scan_sel_q]) begin
            scan_sel_q <= scan_sel_q + 4'h1;
        end
    end
    assign ADC_INPUT_SELECT_OUT = scan_sel_q;

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            position_q <= 3'h0;
        end else if (ADC_SCAN_STEP_IN) begin
            position_q <= ph_val;
        end
    end
    assign PHASE_POSITION_OUT = position_q;

    // Push button: hibernate, wake and long press reset
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            hib_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            wake_q <= 1'b0;
            if (hib_q && pb_low && !pb_low_prev) begin
                hib_q  <= 1'b0;
                wake_q <= 1'b1;
            end else if (wr_en && addr_q == `CTRL_OFS && HWDATA_IN[`CTRL_HIB_BIT]) begin
                hib_q <= 1'b1;
            end
        end
    end
    assign HIBERNATE_OUT = hib_q;
    assign WAKE_OUT      = wake_q;

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            press_cnt_q <= 32'h0000_0000;
            rst_out_q   <= 1'b0;
        end else if (!pb_low || hib_q) begin
            press_cnt_q <= 32'h0000_0000;
            rst_out_q   <= 1'b0;
        end else if (press_cnt_q <= 32'(LONG_PRESS_CYCLES)) begin
            press_cnt_q <= press_cnt_q + 32'h1;
        end else begin
            rst_out_q <= 1'b1;
        end
    end
    assign CONTROLLER_RESET_OUT = rst_out_q;

    // AHB-Lite slave: writes take no wait state, reads one
    assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign wr_en   = wr_pend_q;

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && HWRITE_IN;
            rd_pend_q <= addr_ok && !HWRITE_IN;
            if (addr_ok) begin
                addr_q <= {HADDR_IN[7:2], 2'b00};
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            ctrl_q      <= `REG_RESET;
            cmp_cfg_q   <= `REG_RESET;
            edge_mask_q <= `REG_RESET;
            prot_mask_q <= `REG_RESET;
            thresh_q    <= `REG_RESET;
            io_cfg_q    <= `REG_RESET;
            io_data_q   <= `REG_RESET;
            amp_cfg_q   <= `REG_RESET;
            scan_mask_q <= `REG_RESET;
            cmp_route_q <= `REG_RESET;
            io_route_q  <= `REG_RESET;
        end else if (wr_en) begin
            unique case (addr_q)
                `CTRL_OFS:      ctrl_q      <= HWDATA_IN & 32'h0000_00f5;
                `CMP_CFG_OFS:   cmp_cfg_q   <= HWDATA_IN & 32'h003f_7fff;
                `EDGE_MASK_OFS: edge_mask_q <= HWDATA_IN & 32'h0000_ffff;
                `PROT_MASK_OFS: prot_mask_q <= HWDATA_IN & 32'h003f_3f3f;
                `THRESH_OFS:    thresh_q    <= HWDATA_IN & 32'h03ff_00ff;
                `IO_CFG_OFS:    io_cfg_q    <= HWDATA_IN & 32'h03ff_03ff;
                `IO_DATA_OFS:   io_data_q   <= HWDATA_IN & 32'h0000_03ff;
                `AMP_CFG_OFS:   amp_cfg_q   <= HWDATA_IN & 32'h00ff_ffff;
                `SCAN_MASK_OFS: scan_mask_q <= HWDATA_IN & 32'h0000_ffff;
                `CMP_ROUTE_OFS: cmp_route_q <= HWDATA_IN & 32'h0000_0fff;
                `IO_ROUTE_OFS:  io_route_q  <= HWDATA_IN & 32'h3fff_ffff;
                default: ;
            endcase
        end
    end

    // Sticky flags: a new event wins over a write-one clear
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            edge_flag_q <= 16'h0000;
            pb_event_q  <= 1'b0;
        end else begin
            if (wr_en && addr_q == `EDGE_FLAG_OFS) begin
                edge_flag_q <= (edge_flag_q & ~HWDATA_IN[15:0]) | edge_set;
            end else begin
                edge_flag_q <= edge_flag_q | edge_set;
            end
            if (pb_low && !pb_low_prev) begin
                pb_event_q <= 1'b1;
            end else if (wr_en && addr_q == `STATUS_OFS && HWDATA_IN[`STAT_PB_EVENT_BIT]) begin
                pb_event_q <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_q)
            `CTRL_OFS:      rd_mux = ctrl_q;
            `CMP_CFG_OFS:   rd_mux = cmp_cfg_q;
            `EDGE_MASK_OFS: rd_mux = edge_mask_q;
            `PROT_MASK_OFS: rd_mux = prot_mask_q;
            `THRESH_OFS:    rd_mux = thresh_q;
            `IO_CFG_OFS:    rd_mux = io_cfg_q;
            `IO_DATA_OFS:   rd_mux = {16'h0000, 6'h00, io_in_val};
            `STATUS_OFS:    rd_mux = {13'h0000, hib_q, pb_event_q, pb_low, 3'b000,
                                      prot_val, ph_val, gp_val};
            `EDGE_FLAG_OFS: rd_mux = {16'h0000, edge_flag_q};
            `AMP_CFG_OFS:   rd_mux = amp_cfg_q;
            `SCAN_MASK_OFS: rd_mux = scan_mask_q;
            `CMP_ROUTE_OFS: rd_mux = cmp_route_q;
            `IO_ROUTE_OFS:  rd_mux = io_route_q;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            rdata_q <= rd_mux;
        end
    end

    logic rd_done_q;
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= rd_pend_q;
        end
    end

    assign HRDATA_OUT    = rdata_q;
    assign HREADYOUT_OUT = ~(rd_pend_q & ~rd_done_q);
    assign HRESP_OUT     = 1'b0;

endmodule : afe_event_router

//--- verification/afe_event_router_chk.sv
// Port-level assertions for the front end event router
`timescale 1ns/1ps
module afe_event_router_chk #(
    parameter int LONG_PRESS_CYCLES = 20
) (
    input wire logic       MCLK_IN,
    input wire logic       RST_N_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic [3:0] GENERAL_COMPARATOR_IN,
    input wire logic [5:0] PROTECTION_COMPARATOR_IN,
    input wire logic       PUSH_BUTTON_INPUT_N_IN,
    input wire logic [9:0] FRONT_END_IO_PIN_IN,
    input wire logic       ADC_SCAN_STEP_IN,
    input wire logic [9:0] FRONT_END_IO_PIN_OUT,
    input wire logic [2:0] PHASE_POSITION_OUT,
    input wire logic       MAIN_INTERRUPT_LINE_OUT,
    input wire logic       SECOND_INTERRUPT_LINE_OUT,
    input wire logic       PROTECTION_EVENT_ONE_OUT,
    input wire logic       PROTECTION_EVENT_TWO_OUT,
    input wire logic       HIBERNATE_OUT,
    input wire logic       WAKE_OUT,
    input wire logic       CONTROLLER_RESET_OUT
);
    logic [3:0]  quiet_q;
    logic [13:0] src_q;
    int          low_q;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Quiet cycles
    always_ff @(posedge MCLK_IN) begin
        src_q <= {GENERAL_COMPARATOR_IN, FRONT_END_IO_PIN_IN};
        if (!RST_N_IN || src_q != {GENERAL_COMPARATOR_IN, FRONT_END_IO_PIN_IN} || HTRANS_IN[1]) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hf) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    // Hold length
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN || PUSH_BUTTON_INPUT_N_IN) begin
            low_q <= 0;
        end else begin
            low_q <= low_q + 1;
        end
    end
    property p_main_quiet; (PROTECTION_COMPARATOR_IN == 6'h00) [*4] |=> !MAIN_INTERRUPT_LINE_OUT; endproperty
    a_main_quiet: assert property (p_main_quiet) else $error("main int idle");
    property p_event_quiet;
        (PROTECTION_COMPARATOR_IN == 6'h00) [*4] |=> !PROTECTION_EVENT_ONE_OUT && !PROTECTION_EVENT_TWO_OUT;
    endproperty
    a_event_quiet: assert property (p_event_quiet) else $error("event idle");
    property p_second_cause; $rose(SECOND_INTERRUPT_LINE_OUT) |-> quiet_q < 4'h7; endproperty
    a_second_cause: assert property (p_second_cause) else $error("second int no edge");
    property p_wake_pulse; WAKE_OUT |=> !WAKE_OUT; endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
    property p_wake_cause; WAKE_OUT |-> $past(HIBERNATE_OUT) && !$past(PUSH_BUTTON_INPUT_N_IN, 2); endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake no cause");
    property p_long_press; $rose(CONTROLLER_RESET_OUT) |-> low_q > LONG_PRESS_CYCLES; endproperty
    a_long_press: assert property (p_long_press) else $error("short hold reset");
    property p_phase_step; $changed(PHASE_POSITION_OUT) |-> $past(ADC_SCAN_STEP_IN); endproperty
    a_phase_step: assert property (p_phase_step) else $error("position no step");
    property p_open_drain; FRONT_END_IO_PIN_OUT == 10'h000; endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven");
endmodule : afe_event_router_chk

bind afe_event_router afe_event_router_chk #(.LONG_PRESS_CYCLES(LONG_PRESS_CYCLES)) u_chk (.*);

//--- verification/afe_far_side.sv
// Far side: sequencer steps and trip latch
`timescale 1ns/1ps
module afe_far_side (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       event_one_in,
    input  wire logic [3:0] step_gap_in,
    output logic            scan_step_out,
    output logic            trip_out
);
    logic [3:0] gap_q;
    // One-cycle step pulses, gap of zero stops the sequencer
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || step_gap_in == 4'h0) begin
            gap_q         <= 4'h0;
            scan_step_out <= 1'b0;
        end else begin
            scan_step_out <= (gap_q == step_gap_in);
            gap_q         <= (gap_q == step_gap_in) ? 4'h0 : gap_q + 4'h1;
        end
    end
    // Trip latch
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            trip_out <= 1'b0;
        end else begin
            trip_out <= trip_out | event_one_in;
        end
    end
endmodule : afe_far_side

//--- verification/afe_event_router_tb.sv
// Self-checking bench of the front end event router
`timescale 1ns/1ps
`include "afe_event_regs.svh"
module afe_event_router_tb;
    import afe_event_pkg::*;
    localparam int LP = 20;
    logic           clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, pb_n = 1'b1, e1;
    logic [1:0]     htrans = 2'h0;
    logic [31:0]    haddr = 32'h0, hwdata = 32'h0, hrdata, rd, m;
    logic [3:0]     gp = 4'h0, gap = 4'h0, adc, w;
    logic [2:0]     ph = 3'h0, pos;
    logic [5:0]     prot = 6'h0;
    logic [9:0]     pins = 10'h0, pin_out, pin_oe;
    logic [6:0]     dsm_out, dsm_oe;
    logic           hready, hresp, step, mint, sint, ev1, ev2, hib, wake, crst, trip;
    analog_cfg_type cfg;
    int             error_cnt = 0, check_count = 0, cyc = 0;
    afe_event_router #(.LONG_PRESS_CYCLES(LP)) u_dut (
        .MCLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .GENERAL_COMPARATOR_IN(gp), .PHASE_COMPARATOR_IN(ph),
        .PROTECTION_COMPARATOR_IN(prot), .PUSH_BUTTON_INPUT_N_IN(pb_n), .FRONT_END_IO_PIN_IN(pins & ~pin_oe),
        .FRONT_END_IO_PIN_OUT(pin_out), .FRONT_END_IO_PIN_OE_OUT(pin_oe), .DIGITAL_SIGNAL_MATRIX_IN(dsm_out & dsm_oe),
        .DIGITAL_SIGNAL_MATRIX_OUT(dsm_out), .DIGITAL_SIGNAL_MATRIX_OE_OUT(dsm_oe), .ADC_SCAN_STEP_IN(step),
        .ADC_INPUT_SELECT_OUT(adc), .PHASE_POSITION_OUT(pos), .ANALOG_CFG_OUT(cfg), .MAIN_INTERRUPT_LINE_OUT(mint),
        .SECOND_INTERRUPT_LINE_OUT(sint), .PROTECTION_EVENT_ONE_OUT(ev1), .PROTECTION_EVENT_TWO_OUT(ev2),
        .HIBERNATE_OUT(hib), .WAKE_OUT(wake), .CONTROLLER_RESET_OUT(crst));
    afe_far_side u_far (.clk_in(clk), .rst_n_in(rst_n), .event_one_in(ev1), .step_gap_in(gap),
        .scan_step_out(step), .trip_out(trip));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t: %h != %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        tick(2);
    endtask : bus
    task automatic wrap_up();
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    function automatic int eidx(input int s, input int fall);
        return (s < 4) ? s + 4 * fall : s + 4 + 4 * fall;
    endfunction : eidx
    function automatic logic [31:0] io_exp(input logic [9:0] lvl, input logic oe0, input logic low);
        return 32'((lvl & ~{9'h0, oe0}) ^ {10{low}});
    endfunction : io_exp
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(31));
        tick(6);
        rst_n <= 1'b1;
        tick(1);
        bus(1'b0, 8'h3c, 32'h0);
        chk(rd ^ {27'h0, hresp, mint, sint, hib, crst}, 32'h0);
        for (int g = 0; g < 8; g++) begin
            m = {8'h0, {4{3'(g)}}, 3'($urandom), {3{3'(g)}}};
            bus(1'b1, `AMP_CFG_OFS, m);
            chk(32'({cfg.single_gain, cfg.sample_hold, cfg.diff_gain}), m);
        end
        for (int r = 0; r < 4; r++) begin
            m = {10'h0, {3{2'(r)}}, 4'h0, 4'($urandom), 8'h0};
            bus(1'b1, `CMP_CFG_OFS, m);
            chk(32'({cfg.gp_ref_matrix, cfg.phase_ref}), {22'h0, m[11:8], m[21:16]});
        end
        m = $urandom;
        bus(1'b1, `THRESH_OFS, m);
        chk(32'({cfg.limit_threshold_code, cfg.high_speed_threshold_code}), {14'h0, m[25:16], m[7:0]});
        e1 = 1'b0;
        for (int i = 0; i < 7; i++) begin
            m = (i == 6) ? 32'h0 : $urandom & 32'h003f_3f3f;
            bus(1'b1, `PROT_MASK_OFS, m);
            prot <= (i == 6) ? 6'h3f : 6'(1 << i);
            tick(6);
            chk({mint, ev1, ev2}, {|(prot & m[5:0]), |(prot & m[13:8]), |(prot & m[21:16])});
            e1 = e1 | (|(prot & m[13:8]));
            bus(1'b0, `STATUS_OFS, 32'h0);
            chk(32'(rd[12:7]), 32'(prot));
            prot <= 6'h0;
        end
        chk(trip, e1);
        bus(1'b1, `EDGE_FLAG_OFS, 32'hffff);
        for (int s = 0; s < 8; s++) begin
            m = $urandom & 32'hffff;
            bus(1'b1, `EDGE_MASK_OFS, m);
            for (int f = 0; f < 2; f++) begin
                {pins[9:6], gp} <= f ? 8'h0 : 8'(1 << s);
                tick(6);
                chk(sint, m[eidx(s, f)]);
                bus(1'b0, `EDGE_FLAG_OFS, 32'h0);
                chk(rd, 32'(m[eidx(s, f)]) << eidx(s, f));
                bus(1'b1, `EDGE_FLAG_OFS, 32'hffff);
            end
        end
        bus(1'b1, `EDGE_MASK_OFS, 32'h0);
        gp <= 4'($urandom);
        ph <= 3'($urandom);
        bus(1'b1, `CMP_ROUTE_OFS, 32'h1);
        bus(1'b1, `CMP_CFG_OFS, 32'h5015);
        bus(1'b0, `STATUS_OFS, 32'h0);
        chk(32'(rd[6:1]), 32'({ph ^ 3'h5, gp[3:1] ^ 3'h2}));
        chk({dsm_oe[0], dsm_out[0]}, {1'b1, ~gp[0]});
        gap <= 4'h2;
        tick(8);
        chk(pos, ph ^ 3'h5);
        m = $urandom & 32'hf0;
        bus(1'b1, `CTRL_OFS, m);
        chk(adc, m[7:4]);
        m = $urandom & 32'h7ffe;
        bus(1'b1, `SCAN_MASK_OFS, m);
        gap <= 4'hf;
        bus(1'b1, `CTRL_OFS, 32'h4);
        repeat (6) begin
            do @(negedge clk); while (step !== 1'b1);
            chk(m[adc], 1'b0);
        end
        @(posedge clk);
        gap <= 4'h0;
        bus(1'b1, `CTRL_OFS, 32'h1);
        pb_n <= 1'b0;
        tick(8);
        pb_n <= 1'b1;
        bus(1'b0, `STATUS_OFS, 32'h0);
        chk(32'(rd[18:17]), 32'h1);
        bus(1'b1, `STATUS_OFS, 32'h2_0000);
        bus(1'b1, `CTRL_OFS, 32'h3);
        chk(hib, 1'b1);
        pb_n <= 1'b0;
        w = 4'h0;
        repeat (8) begin
            @(negedge clk);
            w += 4'(wake);
        end
        @(posedge clk);
        chk({w, hib}, {4'h1, 1'b0});
        pb_n <= 1'b1;
        tick(6);
        pb_n <= 1'b0;
        tick(LP - 2);
        chk(crst, 1'b0);
        tick(12);
        chk(crst, 1'b1);
        pb_n <= 1'b1;
        tick(6);
        chk(crst, 1'b0);
        for (int k = 0; k < 4; k++) begin
            m = {6'h0, {10{k[1]}}, 15'h0, 1'b1};
            pins <= 10'($urandom);
            bus(1'b1, `IO_CFG_OFS, m);
            bus(1'b1, `IO_DATA_OFS, 32'(k[0]));
            tick(4);
            chk({pin_out, pin_oe[0]}, {10'h0, ~(k[0] ^ k[1])});
            bus(1'b0, `IO_DATA_OFS, 32'h0);
            chk(rd, io_exp(pins, ~(k[0] ^ k[1]), k[1]));
        end
        wrap_up();
    end
endmodule : afe_event_router_tb
